// ===== verif/pcb_bus_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_bus_monitor
  import pcb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // resolved lines and device enables
  input wire pcb_lines_t lines,
  input wire pcb_lines_t dev_oe,
  // one-way wires
  input wire logic config_select,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  // device mode pin, needed to judge claims
  input wire logic local_config_mode,
  // device extension strobes
  input wire logic ext_address_strobe_n,
  input wire logic ext_data_strobe_n,
  input wire logic ext_burst_last_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // config command decode and the frame of a cycle the device drives
  wire logic cfg_cmd = lines.command_byte_enable_n[3:1] == 3'h5;
  wire logic own_frame = dev_oe.cycle_frame_n && !lines.cycle_frame_n;

  par_even_a: assert property (dev_oe.bus_parity &&
    $past(dev_oe.address_data[0]) |-> lines.bus_parity ==
    ^{$past(lines.address_data), $past(lines.command_byte_enable_n)})
    else $error("parity not even");
  rst_float_a: assert property ($rose(nrst) |-> dev_oe == '0)
    else $error("lines driven after reset");
  grant_start_a: assert property (own_frame &&
    $past(lines.cycle_frame_n) |-> $past(bus_grant_n) == 1'b0)
    else $error("start without grant");
  req_hold_a: assert property ($fell(bus_request_n) |=>
    ##[0:3] own_frame)
    else $error("request not followed by start");
  no_claim_a: assert property (own_frame && $past(lines.cycle_frame_n)
    ##0 lines.device_select_n [*6] |=>
    lines.cycle_frame_n && lines.initiator_ready_n)
    else $error("unclaimed cycle not ended");
  cfg_claim_a: assert property ($fell(lines.cycle_frame_n) &&
    !dev_oe.cycle_frame_n && config_select && cfg_cmd &&
    !local_config_mode |=> dev_oe.device_select_n &&
    !lines.device_select_n)
    else $error("config cycle not claimed");
  lms_ignore_a: assert property ($fell(lines.cycle_frame_n) &&
    config_select && local_config_mode |=> !dev_oe.device_select_n)
    else $error("select honoured in local mode");
  tgt_release_a: assert property (dev_oe.target_ready_n &&
    !lines.target_ready_n && !lines.initiator_ready_n &&
    lines.cycle_frame_n |=> lines.target_ready_n ##1
    !dev_oe.target_ready_n && !dev_oe.device_select_n)
    else $error("target lines not released");
  addr_strobe_a: assert property (own_frame &&
    $past(lines.cycle_frame_n) |-> !ext_address_strobe_n ##1
    ext_address_strobe_n)
    else $error("address strobe not one cycle with frame");
  data_strobe_a: assert property (dev_oe.initiator_ready_n &&
    !lines.initiator_ready_n && !lines.target_ready_n |=>
    !ext_data_strobe_n)
    else $error("data strobe missing after moved word");
  burst_last_a: assert property (!ext_burst_last_n |->
    dev_oe.cycle_frame_n && lines.cycle_frame_n &&
    !lines.initiator_ready_n)
    else $error("burst last outside final phase");
endmodule
`default_nettype wire

// ===== verif/test_pci_bus_signal_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_pci_bus_signal_interface;
  import pcb_pkg::*;
  logic clock, nrst, ce, local_config_mode, perr_en, serr_en;
  logic irq_pending, irq_mask, ini_start, ini_write, ini_done, ini_abort;
  logic [31:0] ini_addr, ini_wdata, ini_rdata, tgt_rdata, h_addr, h_wdata;
  logic [3:0] ini_len, ini_be_n, h_be_n;
  logic tgt_stop_req, wr_valid, wr_ready, h_start, h_write, h_cfg;
  logic h_busy, h_done, h_abort, h_tgt_en, h_irq, ini_busy, ini_beat;
  logic [35:0] wr_data;
  logic [31:0] h_rdata, h_tgt_rdata, h_tgt_wdata;
  logic [1:0] res;
  logic xas_n, xds_n, xbl_n;
  int err_count, total_checks;

  pcb_bus_if pcb_bus_if_inst();
  pcb_device pcb_device_inst(.clock(clock), .nrst(nrst), .ce(ce),
    .bus(pcb_bus_if_inst), .local_config_mode(local_config_mode),
    .perr_en(perr_en), .serr_en(serr_en), .irq_pending(irq_pending),
    .irq_mask(irq_mask), .ini_start(ini_start), .ini_write(ini_write),
    .ini_addr(ini_addr), .ini_len(ini_len), .ini_be_n(ini_be_n),
    .ini_wdata(ini_wdata), .ini_busy(ini_busy), .ini_beat(ini_beat),
    .ini_rdata(ini_rdata), .ini_done(ini_done), .ini_abort(ini_abort),
    .ext_address_strobe_n(xas_n), .ext_data_strobe_n(xds_n),
    .ext_burst_last_n(xbl_n),
    .tgt_rdata(tgt_rdata), .tgt_stop_req(tgt_stop_req),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
  pcb_host pcb_host_inst(.clock(clock), .nrst(nrst), .ce(ce),
    .bus(pcb_bus_if_inst), .h_start(h_start), .h_write(h_write),
    .h_cfg(h_cfg), .h_addr(h_addr), .h_be_n(h_be_n), .h_wdata(h_wdata),
    .h_busy(h_busy), .h_rdata(h_rdata), .h_done(h_done),
    .h_abort(h_abort), .h_tgt_en(h_tgt_en), .h_tgt_rdata(h_tgt_rdata),
    .h_tgt_wvalid(), .h_tgt_wdata(h_tgt_wdata), .h_serr(), .h_irq(h_irq));
  pcb_bus_monitor pcb_bus_monitor_inst(.clock(clock), .nrst(nrst),
    .lines(pcb_bus_if_inst.lines), .dev_oe(pcb_bus_if_inst.dev_oe),
    .config_select(pcb_bus_if_inst.config_select),
    .bus_request_n(pcb_bus_if_inst.bus_request_n),
    .bus_grant_n(pcb_bus_if_inst.bus_grant_n),
    .local_config_mode(local_config_mode),
    .ext_address_strobe_n(xas_n), .ext_data_strobe_n(xds_n),
    .ext_burst_last_n(xbl_n));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // pulse a start at the falling edge, wait for done or abort
  task automatic dev_op(input logic wr, input logic [31:0] a, d);
    @(negedge clock);
    {ini_write, ini_addr, ini_wdata, ini_start} = {wr, a, d, 1'b1};
    @(negedge clock);
    ini_start = 1'b0;
    chk(36'(ini_busy), 36'h1);
    for (int n = 0; n < 40 && ini_done !== 1'b1 && ini_abort !== 1'b1; n++)
      @(negedge clock);
    res = {ini_abort, ini_done};
    chk(36'(ini_beat), 36'(res[0]));
  endtask

  task automatic host_go(input logic c, w, input logic [31:0] a,
                         input logic [3:0] b, input logic [31:0] d);
    @(negedge clock);
    {h_cfg, h_write, h_addr, h_be_n, h_wdata} = {c, w, a, b, d};
    h_start = 1'b1;
    @(negedge clock);
    h_start = 1'b0;
  endtask

  // busy may stall on a full buffer, so the wait is bounded
  task automatic host_op(input logic c, w, input logic [31:0] a,
                         input logic [3:0] b, input logic [31:0] d);
    host_go(c, w, a, b, d);
    for (int n = 0; n < 40 && h_done !== 1'b1 && h_abort !== 1'b1; n++)
      @(negedge clock);
    res = {h_abort, h_done};
  endtask

  task automatic t_dev_rw();
    dev_op(1'b1, 32'h0002_0040, 32'hcafe_0001);
    chk(36'(res), 36'h1);
    chk(36'(h_tgt_wdata), 36'hcafe_0001);
    h_tgt_rdata = 32'h1357_9bdf;
    dev_op(1'b0, 32'h0002_0044, 32'h0);
    chk(36'(ini_rdata), 36'h1357_9bdf);
    h_tgt_en = 1'b0;
    dev_op(1'b1, 32'h0002_0048, 32'h0);
    chk(36'(res), 36'h2);
    h_tgt_en = 1'b1;
  endtask

  task automatic t_host_read();
    host_op(1'b0, 1'b0, 32'h0001_0010, 4'h0, 32'h0);
    chk(36'(h_rdata), 36'h5a5a_1234);
    {tgt_stop_req, tgt_rdata} = {1'b1, 32'h0};
    host_op(1'b0, 1'b0, 32'h0001_0020, 4'h0, 32'h0);
    chk(36'({res, h_rdata}), 36'h1_5a5a_1234);
    tgt_stop_req = 1'b0;
  endtask

  // fill the stream buffer until it stalls, then drain in order
  task automatic t_fill();
    wr_ready = 1'b0;
    for (int i = 0; i < 16; i++)
      host_op(1'b1, 1'b1, 32'h10, 4'(i), 32'h1000_0000 + i);
    host_go(1'b1, 1'b1, 32'h10, 4'h0, 32'h1000_0010);
    repeat (10) @(negedge clock);
    chk(36'(h_busy), 36'h1);
    wr_ready = 1'b1;
    for (int i = 0; i < 17; i++) begin
      for (int n = 0; n < 20 && wr_valid !== 1'b1; n++)
        @(negedge clock);
      chk(wr_data, {4'(i), 32'h1000_0000 + i});
      @(negedge clock);
    end
    chk(36'(wr_valid), 36'h0);
  endtask

  task automatic t_local_mode();
    local_config_mode = 1'b1;
    host_op(1'b1, 1'b1, 32'h10, 4'h0, 32'hdead_beef);
    chk(36'(res), 36'h2);
    local_config_mode = 1'b0;
  endtask

  task automatic t_irq();
    irq_pending = 1'b1;
    repeat (3) @(negedge clock);
    chk(36'(h_irq), 36'h1);
    irq_mask = 1'b1;
    repeat (3) @(negedge clock);
    chk(36'(h_irq), 36'h0);
    irq_pending = 1'b0;
  endtask

  // watchdog: all scenarios need well under this many cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    end_sim();
  end

  initial begin
    {nrst, ce, local_config_mode, perr_en, serr_en} = 5'h0b;
    {irq_pending, irq_mask, ini_start, ini_write, tgt_stop_req} = '0;
    {ini_addr, ini_wdata, ini_len, ini_be_n} = '0;
    {h_start, h_write, h_cfg, h_addr, h_be_n, h_wdata} = '0;
    {tgt_rdata, h_tgt_rdata, wr_ready, h_tgt_en} = {32'h5a5a_1234, 34'h3};
    repeat (10) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    t_dev_rw();
    t_host_read();
    t_fill();
    t_local_mode();
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire

// ===== verilog/pcb_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcb_bus_if;
  import pcb_pkg::*;
  // per-party drive and enable of the shared lines
  pcb_lines_t dev_o;
  pcb_lines_t dev_oe;
  pcb_lines_t host_o;
  pcb_lines_t host_oe;
  pcb_lines_t lines;
  // one-way and open-drain wires
  logic config_select;
  logic bus_request_n;
  logic bus_grant_n;
  logic sys_err_o;
  logic sys_err_oe;
  logic system_error_n;
  logic int_o;
  logic int_oe;
  logic interrupt_out_n;

  // undriven lines float high, as through the bus pull-ups
  assign lines = (dev_o & dev_oe) | (host_o & host_oe) | ~(dev_oe | host_oe);
  assign system_error_n = ~sys_err_oe | sys_err_o;
  assign interrupt_out_n = ~int_oe | int_o;

  modport dev (input lines, config_select, bus_grant_n,
               output dev_o, dev_oe, bus_request_n, sys_err_o, sys_err_oe,
               int_o, int_oe);
  modport host (input lines, bus_request_n, system_error_n, interrupt_out_n,
                output host_o, host_oe, config_select, bus_grant_n);
endinterface
`default_nettype wire

// ===== verilog/pcb_device.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_device
  import pcb_pkg::*;
#(
  parameter logic [19:0] MEM_BASE = MEM_BASE_RST
) (
  // clock, reset and enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // shared bus
  pcb_bus_if.dev bus,
  // mode and reporting controls
  input wire logic local_config_mode,
  input wire logic perr_en,
  input wire logic serr_en,
  input wire logic irq_pending,
  input wire logic irq_mask,
  // initiator requests
  input wire logic ini_start,
  input wire logic ini_write,
  input wire logic [31:0] ini_addr,
  input wire logic [LEN_W-1:0] ini_len,
  input wire logic [3:0] ini_be_n,
  input wire logic [31:0] ini_wdata,
  output logic ini_busy,
  output logic ini_beat,
  output logic [31:0] ini_rdata,
  output logic ini_done,
  output logic ini_abort,
  // extension strobes
  output logic ext_address_strobe_n,
  output logic ext_data_strobe_n,
  output logic ext_burst_last_n,
  // target side
  input wire logic [31:0] tgt_rdata,
  input wire logic tgt_stop_req,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [FIFO_W-1:0] wr_data
);
  pcb_ini_t ini_q, ini_d;
  pcb_tgt_t tgt_q, tgt_d;
  pcb_lines_t o_q, oe_q, o_d, oe_d;
  logic frame_prev_q, tgt_wr_q, ini_wr_q, last_q, last_d, seen_q;
  logic achk_q, dchk_q, exp_q, serr_q, int_q, req_n_q;
  logic [31:0] addr_q;
  logic [3:0] be_q;
  logic [LEN_W-1:0] rem_q, rem_d;
  logic [1:0] gap_q, gap_d;
  logic [2:0] dcnt_q;
  logic [FIFO_AW:0] level;
  logic fifo_in_ready;

  // address phase decode on the shared lines
  wire logic [3:0] cmd = bus.lines.command_byte_enable_n;
  wire logic [31:0] ad = bus.lines.address_data;
  wire logic addr_phase = !bus.lines.cycle_frame_n && frame_prev_q &&
                          bus.lines.initiator_ready_n;
  wire logic own = ini_q == I_ADDR || ini_q == I_DATA || ini_q == I_END;
  wire logic cfg_hit = bus.config_select && !local_config_mode &&
                       pcb_is_cfg(cmd);
  wire logic mem_hit = ad[31:MEM_WIN] == MEM_BASE && pcb_is_mem(cmd);
  wire logic claim = addr_phase && !own && tgt_q == T_IDLE &&
                     (cfg_hit || mem_hit);
  wire logic tgt_wr = tgt_q == T_IDLE ? cmd[0] : tgt_wr_q;

  // handshakes: data moves only when both ready lines are low
  wire logic tgt_xfer = tgt_q == T_DATA && !o_q.target_ready_n &&
                        !bus.lines.initiator_ready_n;
  wire logic ini_xfer = ini_q == I_DATA && !o_q.initiator_ready_n &&
                        !bus.lines.target_ready_n;
  wire logic push = tgt_xfer && tgt_wr_q;
  // room counts the word going in now, so ready never overruns
  wire logic room = fifo_in_ready &&
                    (!push || level < FIFO_LEVEL_MAX - 5'h01);
  wire logic timeout = ini_q == I_DATA && !seen_q &&
                       bus.lines.device_select_n &&
                       dcnt_q == DEVSEL_LIMIT - 3'h2; // address + 5 data
  wire logic par_err = exp_q != bus.lines.bus_parity;
  wire logic ini_on = ini_d == I_ADDR || ini_d == I_DATA || ini_d == I_END;
  wire logic ini_irdy = ini_d == I_DATA && gap_d == 2'h0;
  wire logic ini_last = ini_irdy && last_d;

  // target sequencing
  always_comb begin
    tgt_d = tgt_q;
    unique case (tgt_q)
      T_IDLE: if (claim) tgt_d = T_DATA;
      T_DATA: begin
        // frame released and the final phase over, or initiator gone
        if (bus.lines.cycle_frame_n && (tgt_xfer || !o_q.target_stop_n ||
            bus.lines.initiator_ready_n)) begin
          tgt_d = T_END;
        end
      end
      T_END: tgt_d = T_IDLE;
    endcase
  end

  // initiator sequencing; two wait cycles after each word let the
  // user present the next write word
  always_comb begin
    ini_d = ini_q;
    last_d = last_q;
    rem_d = rem_q;
    gap_d = gap_q;
    unique case (ini_q)
      I_IDLE: begin
        rem_d = ini_len == 4'h0 ? 4'h1 : ini_len;
        if (ini_start) ini_d = I_REQ;
      end
      I_REQ: begin
        if (!bus.bus_grant_n && bus.lines.cycle_frame_n &&
            bus.lines.initiator_ready_n) begin
          ini_d = I_ADDR;
        end
      end
      I_ADDR: begin
        ini_d = I_DATA;
        last_d = rem_q == 4'h1;
        gap_d = 2'h0;
      end
      I_DATA: begin
        if (ini_xfer) begin
          rem_d = rem_q - 4'h1;
          gap_d = 2'h2;
          if (last_q) ini_d = I_END;
          else if (rem_q == 4'h2) last_d = 1'b1;
        end else if (gap_q != 2'h0) begin
          gap_d = gap_q - 2'h1;
        end
        if (!bus.lines.target_stop_n) begin
          last_d = 1'b1;
          if (last_q) ini_d = I_END;
          else gap_d = 2'h0;
        end
        if (timeout) ini_d = I_END;
      end
      I_END: ini_d = I_IDLE;
    endcase
  end

  // next drive of the shared lines; all released by default
  always_comb begin
    o_d = LINES_IDLE;
    oe_d = LINES_OFF;
    if (ini_on) begin
      oe_d.cycle_frame_n = 1'b1;
      oe_d.initiator_ready_n = 1'b1;
      oe_d.command_byte_enable_n = 4'hf;
      o_d.cycle_frame_n = !(ini_d == I_ADDR ||
                            (ini_d == I_DATA && !ini_last));
      o_d.initiator_ready_n = !ini_irdy;
      o_d.command_byte_enable_n = ini_d != I_ADDR ? be_q :
                                  ini_wr_q ? CMD_MEM_WR : CMD_MEM_RD;
      if (ini_d == I_ADDR || (ini_d == I_DATA && ini_wr_q)) begin
        oe_d.address_data = '1;
        o_d.address_data = ini_d == I_ADDR ? addr_q : ini_wdata;
      end
    end
    if (tgt_d != T_IDLE) begin
      oe_d.device_select_n = 1'b1;
      oe_d.target_ready_n = 1'b1;
      oe_d.target_stop_n = 1'b1;
      o_d.device_select_n = tgt_d == T_END;
      // reads keep one turnaround cycle before data
      o_d.target_ready_n = !(tgt_d == T_DATA &&
                             (tgt_wr ? room : tgt_q == T_DATA));
      o_d.target_stop_n = !(tgt_d == T_DATA && tgt_stop_req);
      if (tgt_d == T_DATA && tgt_q == T_DATA && !tgt_wr) begin
        oe_d.address_data = '1;
        o_d.address_data = tgt_rdata;
      end
    end
    // parity trails the lines it covers by one cycle
    oe_d.bus_parity = oe_q.address_data[0];
    o_d.bus_parity = pcb_parity(ad, cmd);
    oe_d.data_parity_error_n = dchk_q && par_err && perr_en;
    o_d.data_parity_error_n = 1'b0;
  end

  // bus state and line registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ini_q <= I_IDLE;
      tgt_q <= T_IDLE;
      o_q <= LINES_IDLE;
      oe_q <= LINES_OFF;
      last_q <= 1'b0;
      rem_q <= 4'h0;
      gap_q <= 2'h0;
      frame_prev_q <= 1'b1;
    end else if (ce) begin
      ini_q <= ini_d;
      tgt_q <= tgt_d;
      o_q <= o_d;
      oe_q <= oe_d;
      last_q <= last_d;
      rem_q <= rem_d;
      gap_q <= gap_d;
      frame_prev_q <= bus.lines.cycle_frame_n;
    end
  end

  // request capture, claim timer and parity checking
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 32'h0;
      be_q <= 4'hf;
      ini_wr_q <= 1'b0;
      tgt_wr_q <= 1'b0;
      dcnt_q <= 3'h0;
      seen_q <= 1'b0;
      achk_q <= 1'b0;
      dchk_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (ce) begin
      if (ini_q == I_IDLE && ini_start) begin
        addr_q <= ini_addr;
        be_q <= ini_be_n;
        ini_wr_q <= ini_write;
      end
      if (claim) tgt_wr_q <= cmd[0];
      dcnt_q <= ini_q == I_DATA ? dcnt_q + 3'h1 : 3'h0;
      seen_q <= ini_q == I_DATA && (seen_q || !bus.lines.device_select_n);
      achk_q <= addr_phase;
      dchk_q <= push || (ini_xfer && !ini_wr_q);
      exp_q <= pcb_parity(ad, cmd);
    end
  end

  // sideband lines, user status and extension strobes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serr_q <= 1'b0;
      int_q <= 1'b0;
      req_n_q <= 1'b1;
      ini_busy <= 1'b0;
      ini_beat <= 1'b0;
      ini_rdata <= 32'h0;
      ini_done <= 1'b0;
      ini_abort <= 1'b0;
      ext_address_strobe_n <= 1'b1;
      ext_data_strobe_n <= 1'b1;
      ext_burst_last_n <= 1'b1;
    end else if (ce) begin
      serr_q <= achk_q && par_err && serr_en;
      int_q <= irq_pending && !irq_mask;
      req_n_q <= ini_d != I_REQ;
      ini_busy <= ini_d != I_IDLE;
      ini_beat <= ini_xfer;
      if (ini_xfer && !ini_wr_q) ini_rdata <= ad;
      ini_done <= ini_q == I_DATA && ini_d == I_END && !timeout;
      ini_abort <= timeout;
      ext_address_strobe_n <= ini_d != I_ADDR;
      ext_data_strobe_n <= !ini_xfer;
      ext_burst_last_n <= !ini_last;
    end
  end

  assign bus.dev_o = o_q;
  assign bus.dev_oe = oe_q;
  assign bus.bus_request_n = req_n_q;
  assign bus.sys_err_o = 1'b0;
  assign bus.sys_err_oe = serr_q;
  assign bus.int_o = 1'b0;
  assign bus.int_oe = int_q;

  // target write words with their lane enables; a slow drain stalls
  // the target ready line
  pcb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_wr_fifo (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({cmd, ad}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data),
    .level(level)
  );
endmodule
`default_nettype wire

// ===== verilog/pcb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock, reset and enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  // pointers carry one extra bit so full and empty differ
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign level = wr_q - rd_q;
  assign in_ready = level < (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_q[AW-1:0]];

  // storage needs no reset
  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pcb_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_host
  import pcb_pkg::*;
(
  // clock, reset and enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // shared bus
  pcb_bus_if.host bus,
  // host initiator, one data phase per request
  input wire logic h_start,
  input wire logic h_write,
  input wire logic h_cfg,
  input wire logic [31:0] h_addr,
  input wire logic [3:0] h_be_n,
  input wire logic [31:0] h_wdata,
  output logic h_busy,
  output logic [31:0] h_rdata,
  output logic h_done,
  output logic h_abort,
  // host memory target
  input wire logic h_tgt_en,
  input wire logic [31:0] h_tgt_rdata,
  output logic h_tgt_wvalid,
  output logic [31:0] h_tgt_wdata,
  // sideband status
  output logic h_serr,
  output logic h_irq
);
  pcb_ini_t ini_q, ini_d;
  pcb_tgt_t tgt_q, tgt_d;
  pcb_lines_t o_q, oe_q, o_d, oe_d;
  logic gnt_n_q, idsel_q, frame_prev_q, wr_q, cfg_q, seen_q, twr_q;
  logic [31:0] addr_q, wdata_q;
  logic [3:0] be_q;
  logic [2:0] dcnt_q;

  wire logic [3:0] cmd = bus.lines.command_byte_enable_n;
  wire logic [31:0] ad = bus.lines.address_data;
  wire logic bus_idle = bus.lines.cycle_frame_n && bus.lines.initiator_ready_n;
  wire logic addr_phase = !bus.lines.cycle_frame_n && frame_prev_q &&
                          bus.lines.initiator_ready_n;
  wire logic claim = addr_phase && h_tgt_en && tgt_q == T_IDLE &&
                     ini_q == I_IDLE && pcb_is_mem(cmd);
  wire logic twr = tgt_q == T_IDLE ? cmd[0] : twr_q;
  wire logic xfer = ini_q == I_DATA && !o_q.initiator_ready_n &&
                    !bus.lines.target_ready_n;
  wire logic tgt_xfer = tgt_q == T_DATA && !o_q.target_ready_n &&
                        !bus.lines.initiator_ready_n;
  wire logic timeout = ini_q == I_DATA && !seen_q &&
                       bus.lines.device_select_n &&
                       dcnt_q == DEVSEL_LIMIT - 3'h2;
  wire logic [3:0] ini_cmd = cfg_q ? (wr_q ? CMD_CFG_WR : CMD_CFG_RD) :
                             (wr_q ? CMD_MEM_WR : CMD_MEM_RD);

  // the host waits while the device holds the grant
  always_comb begin
    ini_d = ini_q;
    tgt_d = tgt_q;
    unique case (ini_q)
      I_IDLE: if (h_start) ini_d = I_REQ;
      I_REQ: if (gnt_n_q && bus_idle && tgt_q == T_IDLE) ini_d = I_ADDR;
      I_ADDR: ini_d = I_DATA;
      I_DATA: if (xfer || timeout || !bus.lines.target_stop_n) ini_d = I_END;
      I_END: ini_d = I_IDLE;
    endcase
    unique case (tgt_q)
      T_IDLE: if (claim) tgt_d = T_DATA;
      T_DATA: if (bus.lines.cycle_frame_n && (tgt_xfer ||
                  bus.lines.initiator_ready_n)) tgt_d = T_END;
      T_END: tgt_d = T_IDLE;
    endcase
  end

  // next drive of the shared lines
  always_comb begin
    o_d = LINES_IDLE;
    oe_d = LINES_OFF;
    if (ini_d != I_IDLE && ini_d != I_REQ) begin
      oe_d.cycle_frame_n = 1'b1;
      oe_d.initiator_ready_n = 1'b1;
      oe_d.command_byte_enable_n = 4'hf;
      o_d.cycle_frame_n = ini_d != I_ADDR;
      o_d.initiator_ready_n = ini_d != I_DATA;
      o_d.command_byte_enable_n = ini_d == I_ADDR ? ini_cmd : be_q;
      if (ini_d == I_ADDR || (ini_d == I_DATA && wr_q)) begin
        oe_d.address_data = '1;
        o_d.address_data = ini_d == I_ADDR ? addr_q : wdata_q;
      end
    end
    if (tgt_d != T_IDLE) begin
      oe_d.device_select_n = 1'b1;
      oe_d.target_ready_n = 1'b1;
      oe_d.target_stop_n = 1'b1;
      o_d.device_select_n = tgt_d == T_END;
      o_d.target_ready_n = !(tgt_d == T_DATA && (twr || tgt_q == T_DATA));
      if (tgt_d == T_DATA && tgt_q == T_DATA && !twr) begin
        oe_d.address_data = '1;
        o_d.address_data = h_tgt_rdata;
      end
    end
    oe_d.bus_parity = oe_q.address_data[0];
    o_d.bus_parity = pcb_parity(ad, cmd);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ini_q <= I_IDLE;
      tgt_q <= T_IDLE;
      o_q <= LINES_IDLE;
      oe_q <= LINES_OFF;
      gnt_n_q <= 1'b1;
      idsel_q <= 1'b0;
      frame_prev_q <= 1'b1;
      dcnt_q <= 3'h0;
      seen_q <= 1'b0;
      twr_q <= 1'b0;
    end else if (ce) begin
      ini_q <= ini_d;
      tgt_q <= tgt_d;
      o_q <= o_d;
      oe_q <= oe_d;
      // grant goes to the device only while it requests and the host is idle
      gnt_n_q <= !(!bus.bus_request_n && ini_d == I_IDLE);
      idsel_q <= ini_d == I_ADDR && cfg_q;
      frame_prev_q <= bus.lines.cycle_frame_n;
      dcnt_q <= ini_q == I_DATA ? dcnt_q + 3'h1 : 3'h0;
      seen_q <= ini_q == I_DATA && (seen_q || !bus.lines.device_select_n);
      if (claim) twr_q <= cmd[0];
    end
  end

  // request capture and user status
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      cfg_q <= 1'b0;
      addr_q <= 32'h0;
      wdata_q <= 32'h0;
      be_q <= 4'hf;
      h_busy <= 1'b0;
      h_rdata <= 32'h0;
      h_done <= 1'b0;
      h_abort <= 1'b0;
      h_tgt_wvalid <= 1'b0;
      h_tgt_wdata <= 32'h0;
      h_serr <= 1'b0;
      h_irq <= 1'b0;
    end else if (ce) begin
      if (ini_q == I_IDLE && h_start) begin
        wr_q <= h_write;
        cfg_q <= h_cfg;
        addr_q <= h_addr;
        wdata_q <= h_wdata;
        be_q <= h_be_n;
      end
      h_busy <= ini_d != I_IDLE;
      if (xfer && !wr_q) h_rdata <= ad;
      h_done <= ini_q == I_DATA && ini_d == I_END && !timeout;
      h_abort <= timeout;
      h_tgt_wvalid <= tgt_xfer && twr_q;
      if (tgt_xfer && twr_q) h_tgt_wdata <= ad;
      h_serr <= !bus.system_error_n;
      h_irq <= !bus.interrupt_out_n;
    end
  end

  assign bus.host_o = o_q;
  assign bus.host_oe = oe_q;
  assign bus.config_select = idsel_q;
  assign bus.bus_grant_n = gnt_n_q;
endmodule
`default_nettype wire

// ===== verilog/pcb_pkg.sv
`default_nettype none
package pcb_pkg;
  // shared bus lines, one bit per wire of the bundle
  typedef struct packed {
    logic [31:0] address_data;
    logic [3:0] command_byte_enable_n;
    logic bus_parity;
    logic cycle_frame_n;
    logic initiator_ready_n;
    logic target_ready_n;
    logic target_stop_n;
    logic device_select_n;
    logic data_parity_error_n;
  } pcb_lines_t;

  localparam pcb_lines_t LINES_IDLE = '1;
  localparam pcb_lines_t LINES_OFF = '0;

  // bus commands
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // memory window of the device: 4 kB above this base
  localparam int MEM_WIN = 12;
  localparam logic [19:0] MEM_BASE_RST = 20'h00010;

  // cycles an initiator waits for a claim before giving up
  localparam logic [2:0] DEVSEL_LIMIT = 3'h6;

  // burst length and write stream buffer
  localparam int LEN_W = 4;
  localparam int FIFO_W = 36;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_LEVEL_MAX = 5'h10;

  typedef enum {I_IDLE, I_REQ, I_ADDR, I_DATA, I_END} pcb_ini_t;
  typedef enum {T_IDLE, T_DATA, T_END} pcb_tgt_t;

  // even parity over address/data and command/byte enables
  function automatic logic pcb_parity(input logic [31:0] ad,
                                      input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction

  function automatic logic pcb_is_mem(input logic [3:0] cmd);
    return cmd == CMD_MEM_RD || cmd == CMD_MEM_WR;
  endfunction

  function automatic logic pcb_is_cfg(input logic [3:0] cmd);
    return cmd == CMD_CFG_RD || cmd == CMD_CFG_WR;
  endfunction
endpackage
`default_nettype wire
